/* rscp_pkg.sv */
// Package: strap decode constants and carrier types for the strap/pin mapper
package rscp_pkg;
  // Strap vector layout
  localparam int RSCP_STRAP_W = 8;
  localparam int RSCP_BUS_LSB = 0;
  localparam int RSCP_DIR_BIT = 3;
  localparam int RSCP_ORDER_BIT = 4;
  localparam int RSCP_WAITPOL_BIT = 5;
  localparam int RSCP_DIV_LSB = 6;
  localparam int RSCP_GPIO_W = 7;
  localparam int RSCP_PDAT_W = 18;
  // Reset values of captured straps
  localparam logic [7:0] RSCP_STRAP_RST = 8'h00;
  // Bus type codes
  typedef enum logic [2:0] {
    RSCP_BUS_A = 3'b000,
    RSCP_BUS_SZ1 = 3'b001,
    RSCP_BUS_SZ2 = 3'b010,
    RSCP_BUS_GEN1 = 3'b011,
    RSCP_BUS_GEN2 = 3'b100,
    RSCP_BUS_BE1 = 3'b101,
    RSCP_BUS_BE2 = 3'b110,
    RSCP_BUS_RSV = 3'b111
  } rscp_bus_e;
  // Panel type field values
  localparam logic [1:0] RSCP_PANEL_BIAS_TFT = 2'h2;
  // Captured configuration carrier
  typedef struct packed {
    rscp_bus_e bus_type;
    logic big_endian;
    logic gpio_in;
    logic wait_high;
    logic [1:0] div_sel;
    logic valid;
  } rscp_cfg_s;
endpackage : rscp_pkg

/* rscp_strap_map.sv */
// Reset-time strap capture, bus clock divider and panel pin mapping
//
// Notes on behaviour
// RULE1: straps latched once, at reset release only
// RULE2: bus code plus byte order validity check
// RULE3: direction strap high means inputs, else outputs
// RULE4: wait output polarity follows polarity strap
// RULE5: bus clock divide 1,2,3,4 from straps
// RULE6: address bit zero ignored where unused
// RULE7: host wires upper half on wide bus
// RULE8: direct TFT needs outputs-direction strap
// RULE9: panel type 10 lets spare output bias
// RULE10: passive colour data presented on shift edge
// RULE11: host selects buffer high, registers low
// RULE12: straps held stable; reserved codes flagged
`timescale 1ns/1ns
`default_nettype none
module rscp_strap_map
  import rscp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] config_straps,
  input wire logic host_addr_bit0,
  input wire logic host_space_sel,
  input wire logic wait_req,
  input wire logic [1:0] panel_type_field,
  input wire logic bias_req,
  input wire logic spare_gp_val,
  input wire logic panel_shift_req,
  input wire logic [RSCP_PDAT_W-1:0] panel_pixel,
  input wire logic [RSCP_GPIO_W-1:0] gpio_in,
  input wire logic [RSCP_GPIO_W-1:0] gpio_out_val,
  output var rscp_cfg_s cfg,
  output logic cfg_supported,
  output logic addr_bit0_eff,
  output logic space_is_buffer,
  output logic host_wait_out,
  output logic bus_clk_en,
  output logic spare_output_pin,
  output logic panel_shift_clock,
  output logic [RSCP_PDAT_W-1:0] panel_data_lines,
  output logic [RSCP_GPIO_W-1:0] gpio_out,
  output logic [RSCP_GPIO_W-1:0] gpio_oe,
  output logic [RSCP_GPIO_W-1:0] gpio_in_sync
);

  // ==========================================================
  // Strap synchronisers and reset-release capture
  // ==========================================================
  logic [7:0] strap_s1_reg;
  logic [7:0] strap_s2_reg;
  logic rst_seen_reg;
  rscp_cfg_s cfg_reg;
  rscp_cfg_s cfg_next;

  // Straps are board-level pins, so they pass two flops first
  always_ff @(posedge core_clk) begin
    strap_s1_reg <= config_straps;
    strap_s2_reg <= strap_s1_reg;
  end

  // Decode of the synchronised strap word
  assign cfg_next.bus_type = rscp_bus_e'(strap_s2_reg[RSCP_BUS_LSB +: 3]);
  assign cfg_next.big_endian = strap_s2_reg[RSCP_ORDER_BIT];
  assign cfg_next.gpio_in = strap_s2_reg[RSCP_DIR_BIT];
  assign cfg_next.wait_high = strap_s2_reg[RSCP_WAITPOL_BIT];
  assign cfg_next.div_sel = strap_s2_reg[RSCP_DIV_LSB +: 2];
  assign cfg_next.valid = 1'b1;

  // Capture on the first clock after rstn rises, then freeze
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rst_seen_reg <= 1'b0;
      // Struct is one bit wider than the strap word; valid sits at the bottom
      cfg_reg <= rscp_cfg_s'({RSCP_STRAP_RST, 1'b0});
    end else if (!rst_seen_reg) begin
      rst_seen_reg <= 1'b1;
      cfg_reg <= cfg_next; // see RULE1
    end
  end
  assign cfg = cfg_reg; // see RULE12

  // ==========================================================
  // Bus code validity
  // ==========================================================
  logic code_ok;
  always_comb begin
    case (cfg_reg.bus_type)
      RSCP_BUS_A, RSCP_BUS_GEN1: code_ok = 1'b1; // see RULE2
      RSCP_BUS_SZ1, RSCP_BUS_SZ2,
      RSCP_BUS_BE1, RSCP_BUS_BE2: code_ok = cfg_reg.big_endian;
      RSCP_BUS_GEN2: code_ok = !cfg_reg.big_endian;
      default: code_ok = 1'b0; // see RULE12
    endcase
  end
  assign cfg_supported = code_ok && cfg_reg.valid;

  // ==========================================================
  // Host side pin handling
  // ==========================================================
  // Only the second generic and second size-strobed buses use address bit zero
  wire a0_used = (cfg_reg.bus_type == RSCP_BUS_GEN2) ||
                 (cfg_reg.bus_type == RSCP_BUS_SZ2);
  assign addr_bit0_eff = a0_used & host_addr_bit0; // see RULE6
  // Selection is a host obligation; we just pass it inward
  assign space_is_buffer = host_space_sel; // see RULE11
  // Polarity from the strap; active low until capture, as reset clears wait_high
  assign host_wait_out = cfg_reg.wait_high ? wait_req : !wait_req; // see RULE4

  // ==========================================================
  // Bus clock enable divider
  // ==========================================================
  logic [1:0] div_cnt_reg;
  wire div_wrap = (div_cnt_reg == cfg_reg.div_sel);
  always_ff @(posedge core_clk) begin
    if (!rstn || !rst_seen_reg) begin
      div_cnt_reg <= 2'h0;
    end else begin
      div_cnt_reg <= div_wrap ? 2'h0 : div_cnt_reg + 2'h1; // see RULE5
    end
  end
  assign bus_clk_en = rst_seen_reg && div_wrap; // see RULE5

  // ==========================================================
  // General I/O direction and sync
  // ==========================================================
  logic [RSCP_GPIO_W-1:0] gin_s1_reg;
  logic [RSCP_GPIO_W-1:0] gin_s2_reg;
  always_ff @(posedge core_clk) begin
    gin_s1_reg <= gpio_in;
    gin_s2_reg <= gin_s1_reg;
  end
  assign gpio_in_sync = gin_s2_reg;
  // Held undriven until the strap is known, avoiding a contention spike
  assign gpio_oe = {RSCP_GPIO_W{rst_seen_reg && !cfg_reg.gpio_in}}; // see RULE3
  assign gpio_out = gpio_out_val; // see RULE8

  // ==========================================================
  // Panel outputs
  // ==========================================================
  wire bias_mode = (panel_type_field == RSCP_PANEL_BIAS_TFT);
  logic spare_reg;
  logic shift_reg;
  logic [RSCP_PDAT_W-1:0] pdat_reg;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      spare_reg <= 1'b0;
      shift_reg <= 1'b0;
      pdat_reg <= '0;
    end else begin
      spare_reg <= bias_mode ? bias_req : spare_gp_val; // see RULE9
      shift_reg <= panel_shift_req;
      // Data changes with the rising shift edge so it is valid there
      if (panel_shift_req && !shift_reg) begin
        pdat_reg <= panel_pixel; // see RULE10
      end
    end
  end
  assign spare_output_pin = spare_reg;
  assign panel_shift_clock = shift_reg;
  assign panel_data_lines = pdat_reg;

  // ==========================================================
  // Assertions
  // ==========================================================
  property p_cfg_frozen;
    @(posedge core_clk) disable iff (!rstn)
      $past(rst_seen_reg) |-> $stable(cfg_reg);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) // see RULE1
    else $error("captured straps changed after reset");

  property p_gen2_le;
    @(posedge core_clk) disable iff (!rstn)
      (cfg_reg.bus_type == RSCP_BUS_GEN2) |->
        (cfg_supported == !cfg_reg.big_endian);
  endproperty
  a_gen2_le: assert property (p_gen2_le) // see RULE2
    else $error("bus code 100 validity wrong");

  property p_rsv;
    @(posedge core_clk) disable iff (!rstn)
      (cfg_reg.bus_type == RSCP_BUS_RSV) |-> !cfg_supported;
  endproperty
  a_rsv: assert property (p_rsv) // see RULE12
    else $error("reserved bus code accepted");

  property p_dir;
    @(posedge core_clk) disable iff (!rstn)
      rst_seen_reg |-> (gpio_oe[0] == !cfg_reg.gpio_in);
  endproperty
  a_dir: assert property (p_dir) // see RULE3
    else $error("io direction does not follow strap");

  property p_wait;
    @(posedge core_clk) disable iff (!rstn)
      wait_req |-> (host_wait_out == cfg_reg.wait_high);
  endproperty
  a_wait: assert property (p_wait) // see RULE4
    else $error("wait polarity wrong");

  property p_div4;
    @(posedge core_clk) disable iff (!rstn)
      (bus_clk_en && cfg_reg.div_sel == 2'h3) |->
        ##1 !bus_clk_en [*3] ##1 bus_clk_en;
  endproperty
  a_div4: assert property (p_div4) // see RULE5
    else $error("divide by four spacing wrong");

  property p_a0;
    @(posedge core_clk) disable iff (!rstn)
      (cfg_reg.bus_type == RSCP_BUS_A) |-> !addr_bit0_eff;
  endproperty
  a_a0: assert property (p_a0) // see RULE6
    else $error("unused address bit leaked");

  property p_bias;
    @(posedge core_clk) disable iff (!rstn)
      (bias_mode && bias_req) |=> spare_output_pin;
  endproperty
  a_bias: assert property (p_bias) // see RULE9
    else $error("bias not routed to spare output");

  property p_pdat;
    @(posedge core_clk) disable iff (!rstn)
      (panel_shift_req && !shift_reg) |=>
        (panel_data_lines == $past(panel_pixel));
  endproperty
  a_pdat: assert property (p_pdat) // see RULE10
    else $error("panel data not launched at shift edge");

  c_capture: cover property (@(posedge core_clk) $rose(rst_seen_reg));
  c_div3: cover property (@(posedge core_clk)
    bus_clk_en && cfg_reg.div_sel == 2'h2);
  c_bias: cover property (@(posedge core_clk) bias_mode && bias_req);
  c_unsup: cover property (@(posedge core_clk)
    rst_seen_reg && !cfg_supported);

endmodule : rscp_strap_map
`default_nettype wire

/* rscp_host_model.sv */
// Host bus and board strap model facing the strap mapper
`timescale 1ns/1ns
`default_nettype none
module rscp_host_model (
  input wire logic [7:0] strap_set,
  input wire logic a0_set,
  input wire logic buf_sel,
  output logic [7:0] config_straps,
  output logic host_addr_bit0,
  output logic host_space_sel
);
  // Straps are hard wired on the board, so they simply follow the setting
  assign config_straps = strap_set;
  // Left to the bench so that ignoring the bit can be observed
  assign host_addr_bit0 = a0_set;
  // High selects the display buffer, low the registers
  assign host_space_sel = buf_sel;
  // A wide host in the second size-strobed mode puts its upper data half
  // on the 16-bit port; this model carries no data, so there is no path
  // to exercise here
endmodule : rscp_host_model
`default_nettype wire

/* tb.sv */
// Self-checking bench for the strap mapper
`timescale 1ns/1ns
`default_nettype none
module tb;
  import rscp_pkg::*;
  // ==========
  // Stimulus and observed signals
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] strap_set = 8'h00;
  logic a0_set = 1'b1, buf_sel = 1'b0, wait_req = 1'b1;
  logic [1:0] ptype = 2'h0;
  logic bias_req = 1'b0, spare_gp_val = 1'b0, shift_req = 1'b0;
  logic [17:0] pixel = 18'h00000;
  logic [6:0] gin = 7'h00, gout = 7'h00;
  logic [7:0] straps;
  logic a0, space;
  rscp_cfg_s cfg;
  logic sup, a0_eff, is_buf, wait_out, bclk_en, spare, sclk;
  logic [17:0] pdat;
  logic [6:0] gpio_out, gpio_oe, gpio_sync;
  int n_fail = 0, compares = 0, n;
  // Rows: strap byte, expected support flag on top
  logic [8:0] rows [10] = '{9'h108, 9'h179, 9'h082, 9'h1F3, 9'h12C,
    9'h155, 9'h0AE, 9'h0D7, 9'h014, 9'h14B};
  always #20 core_clk = ~core_clk;
  rscp_host_model host (.strap_set(strap_set), .a0_set(a0_set),
    .buf_sel(buf_sel), .config_straps(straps), .host_addr_bit0(a0),
    .host_space_sel(space));
  rscp_strap_map uut (.core_clk(core_clk), .rstn(rstn),
    .config_straps(straps), .host_addr_bit0(a0), .host_space_sel(space),
    .wait_req(wait_req), .panel_type_field(ptype), .bias_req(bias_req),
    .spare_gp_val(spare_gp_val), .panel_shift_req(shift_req),
    .panel_pixel(pixel), .gpio_in(gin), .gpio_out_val(gout), .cfg(cfg),
    .cfg_supported(sup), .addr_bit0_eff(a0_eff), .space_is_buffer(is_buf),
    .host_wait_out(wait_out), .bus_clk_en(bclk_en),
    .spare_output_pin(spare), .panel_shift_clock(sclk),
    .panel_data_lines(pdat), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .gpio_in_sync(gpio_sync));
  // ==========
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp, got);
    compares++;
    if (exp !== got) begin
      n_fail++;
      $display("BAD %s exp %0h got %0h", what, exp, got);
    end
  endtask : chk
  task automatic give_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  // Long enough for the two-flop strap synchroniser to fill
  task automatic do_reset(input logic [7:0] s);
    @(posedge core_clk);
    rstn <= 1'b0;
    strap_set <= s;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk("valid in reset", 0, cfg.valid);
    chk("oe in reset", 0, gpio_oe);
    @(posedge core_clk);
    rstn <= 1'b1;
  endtask : do_reset
  // ==========
  // Main sequence
  initial begin
    foreach (rows[i]) begin
      do_reset(rows[i][7:0]);
      // Release has not been sampled yet, so nothing is captured
      @(negedge core_clk);
      chk("early valid", 0, cfg.valid);
      chk("early en", 0, bclk_en);
      @(posedge core_clk);
      // Flipped straps after capture must not reach the config
      strap_set <= ~rows[i][7:0];
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      chk("bus", rows[i][2:0], cfg.bus_type);
      chk("order", rows[i][4], cfg.big_endian);
      chk("supported", rows[i][8], sup);
      chk("valid", 1, cfg.valid);
      chk("dir", rows[i][3], cfg.gpio_in);
      chk("oe", rows[i][3] ? 7'h00 : 7'h7F, gpio_oe);
      chk("wait", rows[i][5], wait_out);
      chk("a0", rows[i][2:0] == 3'h4 || rows[i][2:0] == 3'h2, a0_eff);
      n = 0;
      while (bclk_en !== 1'b1 && n < 9) begin
        @(negedge core_clk);
        n++;
      end
      if (n == 9) begin
        n_fail++;
        give_verdict();
      end
      n = 0;
      do begin
        @(negedge core_clk);
        n++;
      end while (bclk_en !== 1'b1 && n < 9);
      chk("divide", rows[i][7:6] + 1, n);
      // With no request the wait output must sit at its inactive level
      @(posedge core_clk);
      wait_req <= 1'b0;
      @(negedge core_clk);
      chk("wait idle", !rows[i][5], wait_out);
      @(posedge core_clk);
      wait_req <= 1'b1;
      $display("row %0d done", i);
    end
    // Direct-drive panel modes need the outputs direction at reset
    do_reset(8'hF3);
    // Panel launch, bias routing and pass-through pins
    @(posedge core_clk);
    pixel <= 18'h2A5C3;
    shift_req <= 1'b1;
    ptype <= 2'h2;
    bias_req <= 1'b1;
    buf_sel <= 1'b1;
    gin <= 7'h55;
    gout <= 7'h3A;
    @(posedge core_clk);
    pixel <= 18'h15A3C;
    @(negedge core_clk);
    chk("shift", 1, sclk);
    chk("pdat", 18'h2A5C3, pdat);
    chk("space", 1, is_buf);
    chk("gout", 7'h3A, gpio_out);
    chk("bias", 1, spare);
    chk("tft oe", 7'h7F, gpio_oe);
    @(posedge core_clk);
    ptype <= 2'h0;
    @(posedge core_clk);
    @(negedge core_clk);
    chk("pdat hold", 18'h2A5C3, pdat);
    chk("spare gp", 0, spare);
    chk("gin sync", 7'h55, gpio_sync);
    // A second shift pulse must launch the newer pixel word
    @(posedge core_clk);
    shift_req <= 1'b0;
    @(posedge core_clk);
    shift_req <= 1'b1;
    @(negedge core_clk);
    chk("shift low", 0, sclk);
    @(negedge core_clk);
    chk("pdat next", 18'h15A3C, pdat);
    $display("panel test done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
